// ===== core/sgc_clk_div.sv
// Bus clock divider producing one enable tick per bus clock edge
`default_nettype none
module sgc_clk_div (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  sgc_ctl_if.div_mp ctl
);
  import sgc_pkg::*;
  logic [1:0] cnt_r;
  logic [1:0] last;
  logic raw_tick;

  // [R2] Divide ratios per select code
  always_comb begin
    unique case (ctl.sel)
      SGC_SEL_48: begin
        last = 2'h0;
        raw_tick = 1'b1;
      end
      SGC_SEL_32: begin
        last = 2'h2;
        raw_tick = (cnt_r != 2'h2);
      end
      SGC_SEL_24: begin
        last = 2'h1;
        raw_tick = (cnt_r == 2'h0);
      end
      SGC_SEL_12: begin
        last = 2'h3;
        raw_tick = (cnt_r == 2'h0);
      end
    endcase
  end

  // A select change mid-period wraps the counter instead of overrunning
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 2'h0;
    end else if (ctl.clk_en) begin
      cnt_r <= (cnt_r >= last) ? 2'h0 : cnt_r + 2'h1;
    end
  end

  // [R12] Ticks only on enabled edges
  assign ctl.tick = raw_tick & ctl.clk_en;

  chk_div_quarter: assert property ( // [R2]
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (ctl.tick && ctl.sel == SGC_SEL_12) |=>
      (ctl.sel != SGC_SEL_12) || !ctl.tick)
    else $error("12 MHz setting ticked on adjacent edges");
  chk_div_two_thirds: assert property ( // [R2]
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (ctl.clk_en && !ctl.tick && ctl.sel == SGC_SEL_32) ##1
      (ctl.clk_en && ctl.sel == SGC_SEL_32) |-> ctl.tick)
    else $error("32 MHz setting skipped two ticks");
endmodule // sgc_clk_div
`default_nettype wire

// ===== core/sgc_ctl_if.sv
// Signals between the control core, the bus divider and the wake timer
`default_nettype none
interface sgc_ctl_if;
  logic clk_en;
  sgc_pkg::sgc_sel_t sel;
  logic tick;
  logic start;
  sgc_pkg::sgc_cnt_t cycles;
  logic settling;
  modport ctrl_mp(output clk_en, sel, start, cycles, input tick, settling);
  modport div_mp(input clk_en, sel, output tick);
  modport wake_mp(input clk_en, start, cycles, output settling);
endinterface
`default_nettype wire

// ===== core/sgc_pkg.sv
// Types shared by the clock control block
`default_nettype none
package sgc_pkg;
  typedef enum logic [1:0] {
    SGC_SEL_48 = 2'h0,
    SGC_SEL_32 = 2'h1,
    SGC_SEL_24 = 2'h2,
    SGC_SEL_12 = 2'h3
  } sgc_sel_t;
  typedef enum logic [1:0] {
    SGC_IDLE = 2'b01,
    SGC_SETTLE = 2'b10
  } sgc_wake_st_t;
  typedef logic [15:0] sgc_cnt_t;
endpackage
`default_nettype wire

// ===== core/sgc_regs.svh
// Register offsets, reset values and timing constants of clock control
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH
`define SGC_BASE_ADDR 32'h5000_0000
`define SGC_OFS_BUS_SEL 8'h00
`define SGC_OFS_GATE 8'h04
`define SGC_OFS_HYST 8'h0C
`define SGC_OFS_ANA 8'h10
`define SGC_OFS_WAKE 8'h18
`define SGC_RST_BUS_SEL 32'h0000_0002
`define SGC_RST_GATE 32'h0000_0001
`define SGC_RST_HYST 32'h0000_0000
`define SGC_RST_ANA 32'h0000_0007
`define SGC_RST_WAKE 32'h0000_0000
`define SGC_MSK_BUS_SEL 32'h0000_0003
`define SGC_MSK_GATE 32'h00FF_FFFE
`define SGC_MSK_HYST 32'h0000_0003
`define SGC_MSK_ANA 32'h0000_001F
`define SGC_MSK_WAKE 32'h0000_0007
`define SGC_ANA_ADC 0
`define SGC_ANA_CAP 1
`define SGC_ANA_XTAL 2
`define SGC_ANA_XSEL 3
`define SGC_ANA_XHF 4
`define SGC_GATE_W 24
`define SGC_CLK_MHZ 40
`define SGC_WAKE_T0_US 200
`define SGC_WAKE_T1_US 300
`define SGC_WAKE_T2_US 400
`define SGC_WAKE_T3_US 500
`define SGC_WAKE_T4_US 600
`define SGC_WAKE_T5_US 700
`define SGC_WAKE_T6_US 900
`define SGC_WAKE_T7_US 1000
`define SGC_RESP_OKAY 2'h0
`define SGC_RESP_SLVERR 2'h2
`endif

// ===== core/sgc_top.sv
// Clock control core: register bank, bus clock select and peripheral gates
//
// Design decision made here: the AXI4-Lite slave port.
`include "sgc_regs.svh"
`default_nettype none
// Function
// [R1] Registers decode at base 0x5000_0000, offsets 00, 04, 0C, 10, 18.
// [R2] Two-bit select picks 48, 32, 24 or 12 MHz bus clock.
// [R3] Clock select resets to 0x2; upper thirty bits reserved.
// [R4] Each peripheral receives clock only while its gate bit is one.
// [R5] Gate register resets to 0x1; all peripheral gates start off.
// [R6] Bits 23..16: display, port, checksum, ADC, sense, watchdog, timers.
// [R7] Bits 15..8 gate timer 1, timer 0, pulse units 4..0, two-wire.
// [R8] Bits 7..3 gate serial 4..0; bits 2, 1 gate sync serial 1, 0.
// [R9] Gate bits 31:24 and 0 are reserved, gating nothing.
// [R10] Three-bit wake code selects 0.2 to 1 ms settle time.
// [R11] Wake register implements only bits 2:0; the rest reserved.
// [R12] Bus clock is the multiplied clock divided; it clocks peripherals.
// [R13] Hysteresis code selects 300, 400, 500 or 600 mV.
// [R14] Analog switches reset to 0x7, crystal, sensing, ADC powered down.
// [R15] After wake, stay off multiplied clock until settle count expires.
// [R16] Reserved bits read zero; gate changes are glitch-free. The code reads reserved gate bit 0 as one.
module sgc_top #(
  parameter int unsigned P_WAKE_CYC [8] = '{
    `SGC_WAKE_T0_US * `SGC_CLK_MHZ, `SGC_WAKE_T1_US * `SGC_CLK_MHZ,
    `SGC_WAKE_T2_US * `SGC_CLK_MHZ, `SGC_WAKE_T3_US * `SGC_CLK_MHZ,
    `SGC_WAKE_T4_US * `SGC_CLK_MHZ, `SGC_WAKE_T5_US * `SGC_CLK_MHZ,
    `SGC_WAKE_T6_US * `SGC_CLK_MHZ, `SGC_WAKE_T7_US * `SGC_CLK_MHZ}
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_wake_req,
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_bus_clk_tick,
  output logic [`SGC_GATE_W-1:0] o_periph_clk_en,
  output logic o_mult_clk_selected,
  output logic [1:0] o_hysteresis_code,
  output logic o_xtal_pd,
  output logic o_cap_sense_pd,
  output logic o_adc_pd,
  output logic o_xtal_high_sel,
  output logic o_xtal_hf_sel
);
  import sgc_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  logic wake_s1_r;
  logic wake_s2_r;
  logic wake_s3_r;
  logic aw_ok_r;
  logic w_ok_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] bus_sel_r;
  logic [31:0] gate_r;
  logic [31:0] hyst_r;
  logic [31:0] ana_r;
  logic [31:0] wake_r;
  logic [`SGC_GATE_W-1:0] gate_out_r;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [7:0] wr_ofs;
  logic wr_map;
  logic [31:0] rd_val;
  logic rd_map;

  sgc_ctl_if ctl ();

  // Reset is released through two flops so every domain leaves it together
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Wake pin is asynchronous: synchronise, then detect the rising edge
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
      wake_s3_r <= 1'b0;
    end else if (i_clk_en) begin
      wake_s1_r <= i_wake_req;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  // [R1] Base and offset decode
  function automatic logic is_mapped(input logic [31:0] a);
    logic [7:0] o;
    o = a[7:0];
    is_mapped = (a[31:8] == `SGC_BASE_ADDR >> 8) && (o == `SGC_OFS_BUS_SEL ||
      o == `SGC_OFS_GATE || o == `SGC_OFS_HYST || o == `SGC_OFS_ANA ||
      o == `SGC_OFS_WAKE);
  endfunction

  // [R16] Byte-lane merge; reserved bits keep their reset values through the mask
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = (r & m) | (old & ~m);
  endfunction

  // Handshakes stall while the clock enable freezes state
  assign o_awready = i_clk_en && !aw_ok_r && !bvalid_r;
  assign o_wready = i_clk_en && !w_ok_r && !bvalid_r;
  assign o_arready = i_clk_en && !rvalid_r;
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign ar_take = i_arvalid && o_arready;
  assign do_write = i_clk_en && aw_ok_r && w_ok_r && !bvalid_r;
  assign wr_ofs = awaddr_r[7:0];
  assign wr_map = is_mapped(awaddr_r);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_ok_r <= 1'b0;
      awaddr_r <= 32'h0000_0000;
    end else if (aw_take) begin
      aw_ok_r <= 1'b1;
      awaddr_r <= i_awaddr;
    end else if (do_write) begin
      aw_ok_r <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_ok_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (w_take) begin
      w_ok_r <= 1'b1;
      wdata_r <= i_wdata;
      wstrb_r <= i_wstrb;
    end else if (do_write) begin
      w_ok_r <= 1'b0;
    end
  end

  // Unmapped addresses still answer, with a slave error
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SGC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? `SGC_RESP_OKAY : `SGC_RESP_SLVERR;
    end else if (i_clk_en && i_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;

  // [R3] Bus clock select register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_sel_r <= `SGC_RST_BUS_SEL;
    end else if (do_write && wr_map && wr_ofs == `SGC_OFS_BUS_SEL) begin
      bus_sel_r <= merge(bus_sel_r, wdata_r, wstrb_r, `SGC_MSK_BUS_SEL);
    end
  end

  // [R5] Gate register; bit 0 is held at its reset one
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= `SGC_RST_GATE;
    end else if (do_write && wr_map && wr_ofs == `SGC_OFS_GATE) begin
      gate_r <= merge(gate_r, wdata_r, wstrb_r, `SGC_MSK_GATE);
    end
  end

  // [R13] Hysteresis select register
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hyst_r <= `SGC_RST_HYST;
    end else if (do_write && wr_map && wr_ofs == `SGC_OFS_HYST) begin
      hyst_r <= merge(hyst_r, wdata_r, wstrb_r, `SGC_MSK_HYST);
    end
  end

  // [R14] Analog switches power up disabled
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_r <= `SGC_RST_ANA;
    end else if (do_write && wr_map && wr_ofs == `SGC_OFS_ANA) begin
      ana_r <= merge(ana_r, wdata_r, wstrb_r, `SGC_MSK_ANA);
    end
  end

  // [R11] Only the three timing bits are kept
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= `SGC_RST_WAKE;
    end else if (do_write && wr_map && wr_ofs == `SGC_OFS_WAKE) begin
      wake_r <= merge(wake_r, wdata_r, wstrb_r, `SGC_MSK_WAKE);
    end
  end

  // [R16] Read mux; reserved bits hold their reset values in storage, gate bit 0 a one
  always_comb begin
    rd_map = is_mapped(i_araddr);
    unique case (i_araddr[7:0])
      `SGC_OFS_BUS_SEL: rd_val = bus_sel_r;
      `SGC_OFS_GATE: rd_val = gate_r;
      `SGC_OFS_HYST: rd_val = hyst_r;
      `SGC_OFS_ANA: rd_val = ana_r;
      `SGC_OFS_WAKE: rd_val = wake_r;
      default: rd_val = 32'h0000_0000;
    endcase
    if (!rd_map) begin
      rd_val = 32'h0000_0000;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `SGC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_map ? `SGC_RESP_OKAY : `SGC_RESP_SLVERR;
    end else if (i_clk_en && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  // [R2] Divider and wake timer hookup
  assign ctl.clk_en = i_clk_en;
  assign ctl.sel = sgc_sel_t'(bus_sel_r[1:0]);
  assign ctl.start = wake_s2_r && !wake_s3_r;
  // [R10] Settle length from the wake code
  assign ctl.cycles = sgc_cnt_t'(P_WAKE_CYC[wake_r[2:0]]);

  sgc_clk_div u_div (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .ctl(ctl.div_mp)
  );

  sgc_wake_timer #(
    .P_CNT_W($bits(sgc_cnt_t))
  ) u_wake (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .ctl(ctl.wake_mp)
  );

  // [R4] Per-peripheral enables registered on bus ticks, so no glitches
  // [R6] [R7] [R8] Bit position equals gate register bit position
  // [R9] Reserved bit 0 drives nothing
  generate
    for (genvar g = 0; g < `SGC_GATE_W; g++) begin : g_gate
      always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
          gate_out_r[g] <= 1'b0;
        end else if (i_clk_en) begin
          gate_out_r[g] <= (g != 0) && gate_r[g] && ctl.tick;
        end
      end
    end
  endgenerate

  assign o_periph_clk_en = gate_out_r;
  assign o_bus_clk_tick = ctl.tick;
  // [R15] Multiplied clock selected only once settled
  assign o_mult_clk_selected = !ctl.settling;
  assign o_hysteresis_code = hyst_r[1:0];
  assign o_xtal_pd = ana_r[`SGC_ANA_XTAL];
  assign o_cap_sense_pd = ana_r[`SGC_ANA_CAP];
  assign o_adc_pd = ana_r[`SGC_ANA_ADC];
  assign o_xtal_high_sel = ana_r[`SGC_ANA_XSEL];
  assign o_xtal_hf_sel = ana_r[`SGC_ANA_XHF];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_base_decode: assert property ( // [R1]
    $rose(bvalid_r) |-> (bresp_r == (is_mapped(awaddr_r) ?
      `SGC_RESP_OKAY : `SGC_RESP_SLVERR)))
    else $error("Write response disagrees with address decode");
  chk_sel_reset: assert property ( // [R3]
    $rose(rst_n) |-> bus_sel_r == `SGC_RST_BUS_SEL)
    else $error("Clock select reset value wrong");
  chk_gate_reset: assert property ( // [R5]
    $rose(rst_n) |-> gate_r == `SGC_RST_GATE && o_periph_clk_en == '0)
    else $error("Gate register reset value wrong");
  chk_gate_follow: assert property ( // [R4]
    (o_periph_clk_en & ~$past(gate_r[`SGC_GATE_W-1:0])) == '0)
    else $error("Peripheral clocked while its gate is off");
  chk_gate_tick: assert property ( // [R12]
    o_periph_clk_en != '0 |-> $past(ctl.tick))
    else $error("Peripheral clock without a bus tick");
  chk_rsvd_gate: assert property ( // [R9]
    !o_periph_clk_en[0] && gate_r[31:`SGC_GATE_W] == '0)
    else $error("Reserved gate bit active");
  chk_wake_rsvd: assert property ( // [R11]
    ar_take && i_araddr[7:0] == `SGC_OFS_WAKE |=> o_rdata[31:3] == '0)
    else $error("Wake register reserved bits read nonzero");
  chk_ana_reset: assert property ( // [R14]
    $rose(rst_n) |-> o_xtal_pd && o_cap_sense_pd && o_adc_pd)
    else $error("Analog blocks not powered down at reset");
  chk_hyst_out: assert property ( // [R13]
    do_write && wr_map && wr_ofs == `SGC_OFS_HYST && wstrb_r[0] |=>
      o_hysteresis_code == $past(wdata_r[1:0]))
    else $error("Hysteresis code did not follow write");
endmodule // sgc_top
`default_nettype wire

// ===== core/sgc_wake_timer.sv
// Settle timer holding the system clock off the multiplied clock
`default_nettype none
module sgc_wake_timer #(
  parameter int P_CNT_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  sgc_ctl_if.wake_mp ctl
);
  import sgc_pkg::*;
  sgc_wake_st_t st_r;
  logic [P_CNT_W-1:0] cnt_r;
  logic [P_CNT_W-1:0] seen_r;
  logic [P_CNT_W-1:0] load_r;

  // [R15] Count the selected settle time, then release
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= SGC_IDLE;
      cnt_r <= '0;
    end else if (ctl.clk_en) begin
      unique case (st_r)
        SGC_IDLE: begin
          if (ctl.start) begin
            st_r <= SGC_SETTLE;
            cnt_r <= ctl.cycles;
          end
        end
        SGC_SETTLE: begin
          if (cnt_r <= P_CNT_W'(1)) begin
            st_r <= SGC_IDLE;
          end
          cnt_r <= cnt_r - P_CNT_W'(1);
        end
        default: st_r <= SGC_IDLE;
      endcase
    end
  end

  assign ctl.settling = (st_r == SGC_SETTLE);

  // Helper: enabled cycles spent settling, and the length requested
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_r <= '0;
      load_r <= '0;
    end else if (ctl.clk_en) begin
      if (st_r == SGC_IDLE && ctl.start) begin
        seen_r <= '0;
        load_r <= ctl.cycles;
      end else if (ctl.settling) begin
        seen_r <= seen_r + P_CNT_W'(1);
      end
    end
  end

  sequence s_wake_go;
    ctl.clk_en && !ctl.settling && ctl.start;
  endsequence
  sequence s_settled;
    $fell(ctl.settling);
  endsequence
  chk_wake_enter: assert property ( // [R15]
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_wake_go |=> ctl.settling)
    else $error("Wake request did not start settling");
  chk_wake_length: assert property ( // [R10]
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_settled |-> (seen_r == load_r))
    else $error("Settle time differs from selected code");
endmodule // sgc_wake_timer
`default_nettype wire

// ===== tb/sgc_tb.sv
// Self-checking bench for the clock control core
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned wake_cyc [8] = '{8, 12, 16, 20, 24, 28, 36, 40};
  localparam logic [31:0] base = 32'h5000_0000;
  logic clk, resetn, clk_en, wake_req;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, tick, mult_sel;
  logic [1:0] bresp, rresp, hyst;
  logic [23:0] pen;
  logic xtal_pd, cap_pd, adc_pd, xsel, xhf;
  int failures, n_compared;

  sgc_top #(.P_WAKE_CYC(wake_cyc)) dut (
    .i_core_clk(clk), .i_resetn(resetn), .i_clk_en(clk_en),
    .i_wake_req(wake_req), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
    .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_bus_clk_tick(tick), .o_periph_clk_en(pen),
    .o_mult_clk_selected(mult_sel), .o_hysteresis_code(hyst),
    .o_xtal_pd(xtal_pd), .o_cap_sense_pd(cap_pd), .o_adc_pd(adc_pd),
    .o_xtal_high_sel(xsel), .o_xtal_hf_sel(xhf));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Counts: %0d compared, %0d failures", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    failures++;
    $display("Error: %s timed out", what);
    end_of_test();
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error: %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Each channel released only after the edge that took it
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int n;
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    n = 0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b && n < 50) begin
      @(negedge clk);
      if (awvalid && awready === 1'b1) aw = 1;
      if (wvalid && wready === 1'b1) w = 1;
      if (bvalid === 1'b1) begin
        b = 1;
        r = bresp;
      end
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
      n++;
    end
    if (!b) hang("write");
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    bit ah, done;
    ah = 0;
    done = 0;
    n = 0;
    d = 32'h0000_0000;
    r = 2'h3;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 50) begin
      @(negedge clk);
      if (arvalid && arready === 1'b1) ah = 1;
      if (rvalid === 1'b1) begin
        done = 1;
        d = rdata;
        r = rresp;
      end
      @(posedge clk);
      if (ah) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      n++;
    end
    if (!done) hang("read");
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk("read data", d, exp);
    chk("read resp", 32'(r), 32'h0000_0000);
  endtask

  task automatic t_reset();
    rd_chk(base + 32'h0000_0000, 32'h0000_0002);
    rd_chk(base + 32'h0000_0004, 32'h0000_0001);
    rd_chk(base + 32'h0000_0010, 32'h0000_0007);
    rd_chk(base + 32'h0000_000C, 32'h0000_0000);
    rd_chk(base + 32'h0000_0018, 32'h0000_0000);
    chk("gates at reset", 32'(pen), 32'h0000_0000);
    chk("pd at reset", {29'h0, xtal_pd, cap_pd, adc_pd},
        32'h0000_0007);
    $display("Test reset done");
  endtask

  task automatic t_regs();
    logic [1:0] r;
    logic [31:0] ofs [5] = '{32'h0000_0000, 32'h0000_0004, 32'h0000_000C,
                             32'h0000_0010, 32'h0000_0018};
    logic [31:0] msk [5] = '{32'h0000_0003, 32'h00FF_FFFF, 32'h0000_0003,
                             32'h0000_001F, 32'h0000_0007};
    // Reserved bits other than gate bit 0 read zero after all-ones
    for (int i = 0; i < 5; i++) begin
      wr(base + ofs[i], 32'hFFFF_FFFF, r);
      chk("write resp", 32'(r), 32'h0000_0000);
      rd_chk(base + ofs[i], msk[i]);
    end
    chk("hyst code", 32'(hyst), 32'h0000_0003);
    chk("analog out", {27'h0, xhf, xsel, xtal_pd, cap_pd, adc_pd},
        32'h0000_001F);
    wr(base + 32'h0000_0010, 32'h0000_0000, r);
    chk("analog on", {27'h0, xhf, xsel, xtal_pd, cap_pd, adc_pd},
        32'h0000_0000);
    wr(base + 32'h0000_000C, 32'h0000_0001, r);
    chk("hyst code", 32'(hyst), 32'h0000_0001);
    $display("Test registers done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    // Holes, misaligned and foreign base are refused
    wr(base + 32'h0000_0014, 32'h0000_0001, r);
    chk("hole write resp", 32'(r), 32'h0000_0002);
    rd(base + 32'h0000_0008, d, r);
    chk("hole read resp", 32'(r), 32'h0000_0002);
    chk("hole read data", d, 32'h0000_0000);
    wr(32'h5000_0100, 32'h0000_0000, r);
    chk("foreign base", 32'(r), 32'h0000_0002);
    wr(base + 32'h0000_0002, 32'h0000_0000, r);
    chk("misaligned", 32'(r), 32'h0000_0002);
    rd_chk(base + 32'h0000_0000, 32'h0000_0003);
    $display("Test unmapped done");
  endtask

  task automatic t_sel();
    logic [1:0] r;
    int n;
    int exp [4] = '{12, 8, 6, 3};
    // Ticks in 12 cycles of the multiplied clock
    for (int c = 0; c < 4; c++) begin
      wr(base, 32'(c), r);
      repeat (4) @(negedge clk);
      n = 0;
      repeat (12) begin
        @(negedge clk);
        if (tick === 1'b1) n++;
      end
      chk("tick count", 32'(n), 32'(exp[c]));
    end
    $display("Test bus select done");
  endtask

  task automatic t_gate();
    logic [1:0] r;
    logic [23:0] acc;
    logic [31:0] pat [4] = '{32'hFFFF_FFFF, 32'h00AA_AAAA, 32'h0055_5555,
                             32'h0000_0000};
    // Clock only where the gate is set
    wr(base, 32'h0000_0000, r);
    for (int i = 0; i < 4; i++) begin
      wr(base + 32'h0000_0004, pat[i], r);
      repeat (2) @(negedge clk);
      acc = 24'h00_0000;
      repeat (8) begin
        @(negedge clk);
        acc = acc | pen;
      end
      chk("gated clocks", 32'(acc), pat[i] & 32'h00FF_FFFE);
    end
    $display("Test gates done");
  endtask

  task automatic t_wake();
    logic [1:0] r;
    int n, cnt;
    // Settle window length per wake code
    for (int c = 0; c < 8; c++) begin
      wr(base + 32'h0000_0018, 32'(c), r);
      @(posedge clk);
      wake_req <= 1'b1;
      n = 0;
      while (mult_sel !== 1'b0 && n < 20) begin
        @(negedge clk);
        n++;
      end
      if (n >= 20) hang("wake start");
      cnt = 0;
      while (mult_sel === 1'b0 && cnt < 100) begin
        @(negedge clk);
        cnt++;
      end
      chk("settle cycles", 32'(cnt), 32'(wake_cyc[c]));
      @(posedge clk);
      wake_req <= 1'b0;
      repeat (4) @(posedge clk);
    end
    $display("Test wake done");
  endtask

  task automatic t_clk_en();
    // Frozen core offers no bus readiness and no ticks
    @(posedge clk);
    clk_en <= 1'b0;
    @(negedge clk);
    chk("frozen ready", {29'h0, awready, wready, arready},
        32'h0000_0000);
    chk("frozen tick", 32'(tick), 32'h0000_0000);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(base + 32'h0000_0004, 32'h0000_0001);
    $display("Test clock enable done");
  endtask

  initial begin
    failures = 0;
    n_compared = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    wake_req = 1'b0;
    awaddr = 32'h0000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    araddr = 32'h0000_0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_regs();
    t_unmapped();
    t_sel();
    t_gate();
    t_wake();
    t_clk_en();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
